// [rgic_consts.svh]
// timing, address and reset constants of the regulator control link
`ifndef RGIC_CONSTS_SVH
`define RGIC_CONSTS_SVH

// core clock
`define RGIC_CLK_PERIOD_NS 8
`define RGIC_CLK_KHZ       125000

// fixed slave address and direction bit values
`define RGIC_SLAVE_ADDR    7'h40
`define RGIC_DIR_WRITE     1'b0
`define RGIC_DIR_READ      1'b1

// voltage-setting register indices and layout
`define RGIC_REG_A         8'h00
`define RGIC_REG_B         8'h01
`define RGIC_REG_RESET     8'h97
`define RGIC_EN_BIT        7
`define RGIC_MODE_BIT      6
`define RGIC_CODE_MSB      5

// bit counter: eight data bits, then the acknowledge slot
`define RGIC_BITS          4'h8
`define RGIC_ACK_SLOT      4'h9

// over-voltage blanking, least time rounds up
`define RGIC_OVP_BLANK_NS  20000
`define RGIC_OVP_CYC       ((`RGIC_OVP_BLANK_NS + `RGIC_CLK_PERIOD_NS - 1) / `RGIC_CLK_PERIOD_NS)
`define RGIC_OVP_CW        12

// serial clock ceiling, quarter period rounds up so the rate stays below it
`define RGIC_SCL_MAX_KHZ   3400
`define RGIC_QUARTER_CYC   ((`RGIC_CLK_KHZ + 4 * `RGIC_SCL_MAX_KHZ - 1) / (4 * `RGIC_SCL_MAX_KHZ))
`define RGIC_QCW           8

// host byte sequence positions
`define RGIC_SEG_ADDR_W    3'h0
`define RGIC_SEG_REG       3'h1
`define RGIC_SEG_WDATA     3'h2
`define RGIC_SEG_ADDR_R    3'h3
`define RGIC_SEG_RDATA     3'h4

`endif

// [rgic_pkg.sv]
// state types of both ends of the regulator control link
package rgic_pkg;
  `include "rgic_consts.svh"

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_ADDR = 3'b001,
    DS_REG  = 3'b010,
    DS_WR   = 3'b011,
    DS_RD   = 3'b100,
    DS_SKIP = 3'b101
  } rgic_dev_st_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_START = 3'b001,
    HS_BIT   = 3'b010,
    HS_STOP  = 3'b011,
    HS_DONE  = 3'b100
  } rgic_host_st_t;

  typedef struct packed {
    rgic_dev_st_t            st;
    logic [3:0]              cnt;
    logic [7:0]              sh;
    logic                    rw;
    logic                    mnack;
    logic [7:0]              ptr;
    logic                    scl_q;
    logic                    sda_q;
    logic                    sda_o;
    logic                    sda_oe;
    logic [7:0]              reg_a;
    logic [7:0]              reg_b;
    logic                    en_q;
    logic                    powerup_start;
    logic                    converter_on;
    logic                    switching_on;
    logic [`RGIC_OVP_CW-1:0] ovp_cnt;
    logic                    ovp_trip;
    logic [5:0]              vout_code;
    logic                    forced_pwm;
  } rgic_dev_t;

  typedef struct packed {
    rgic_host_st_t        st;
    logic [1:0]           ph;
    logic [`RGIC_QCW-1:0] qcnt;
    logic [3:0]           bitn;
    logic [2:0]           seg;
    logic [7:0]           sh;
    logic [7:0]           rx;
    logic                 rd;
    logic [7:0]           reg_adr;
    logic [7:0]           wdata;
    logic                 scl_o;
    logic                 scl_oe;
    logic                 sda_o;
    logic                 sda_oe;
    logic                 ready;
    logic                 done;
    logic                 nack_err;
    logic [7:0]           rdata;
  } rgic_host_t;
endpackage

// [rgic_bus_if.sv]
// two-wire bus between host and regulator, open-drain resolution
`timescale 1ns/1ps
interface rgic_bus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // wired-and with pull-up: a line is low only while someone drives a low
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// [rgic_dev.sv]
// regulator end: bus slave, voltage-setting registers, enable and over-voltage logic
`timescale 1ns/1ps
`include "rgic_consts.svh"
//
// Functional notes
// RULE1 - enable pin low forces output off
// RULE2 - enable pin rising edge launches power-up
// RULE3 - select pin picks which software enable
// RULE4 - both software enables reset to one
// RULE5 - over-voltage stops switching after 20us blanking
// RULE6 - bus clock up to 3.4MHz
// RULE7 - always slave, 7-bit address plus direction
// RULE8 - answer only address 0x40
// RULE9 - start/stop: data edges while clock high
// RULE10 - master makes start/stop, stop before start
// RULE11 - data changes only while clock low
// RULE12 - nine clocks: eight bits msb first, ack
// RULE13 - own address acknowledged on ninth clock
// RULE14 - receiver acknowledges register and data bytes
// RULE15 - direction bit zero write, one read
// RULE16 - no match: line released, not-acknowledge
// RULE17 - second byte is register address, acknowledged
// RULE18 - registers 0x00/0x01 enable bit seven, default one
// RULE19 - writes store data, reads return register
// RULE20 - stop releases line, drops partial byte
module rgic_dev
  import rgic_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // serial link
  rgic_bus_if.dev   bus,
  // converter pins
  input  wire logic en_pin,
  input  wire logic voltage_select_pin,
  input  wire logic input_overvoltage_guard,
  // converter control
  output logic      powerup_start,
  output logic      converter_on,
  output logic      switching_on,
  output logic      ovp_trip,
  output logic [5:0] vout_code,
  output logic      forced_pwm
);

  rgic_dev_t s;
  rgic_dev_t next_s;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sw_en;
  logic [7:0] rd_cur;
  logic [7:0] rd_nxt;

  // register read mux, shared by first and following read bytes
  function automatic logic [7:0] reg_read(input logic [7:0] adr, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] v;
    v = 8'h00;
    if (adr == `RGIC_REG_A) begin
      v = a;
    end else if (adr == `RGIC_REG_B) begin
      v = b;
    end
    return v;
  endfunction

  // line events from the previous sample; link pins are synchronous to core_clk
  assign scl_rise  = bus.scl & ~s.scl_q;
  assign scl_fall  = ~bus.scl & s.scl_q;
  assign start_det = bus.scl & s.scl_q & s.sda_q & ~bus.sda; // RULE9
  assign stop_det  = bus.scl & s.scl_q & ~s.sda_q & bus.sda; // RULE9

  // software enable chosen by the select pin
  assign sw_en = voltage_select_pin ? s.reg_b[`RGIC_EN_BIT] : s.reg_a[`RGIC_EN_BIT]; // RULE3

  // read bytes at the pointer and the one after; a function result cannot be bit-selected in place
  assign rd_cur = reg_read(s.ptr, s.reg_a, s.reg_b); // RULE19
  assign rd_nxt = reg_read(s.ptr + 8'h01, s.reg_a, s.reg_b); // RULE19

  // next state of the whole block
  always_comb begin
    next_s               = s;
    next_s.scl_q         = bus.scl;
    next_s.sda_q         = bus.sda;
    next_s.sda_o         = 1'b0; // open drain: only ever pulls low

    if (stop_det) begin
      // a stop ends everything and throws away any half byte
      next_s.st     = DS_IDLE; // RULE20
      next_s.cnt    = 4'h0;
      next_s.sda_oe = 1'b0; // RULE20
    end else if (start_det) begin
      next_s.st     = DS_ADDR; // RULE7
      next_s.cnt    = 4'h0;
      next_s.sda_oe = 1'b0;
    end else if (s.st != DS_IDLE && s.st != DS_SKIP) begin
      if (scl_rise) begin
        // bits are sampled while clock is high, msb first
        if (s.cnt < `RGIC_BITS) begin
          if (s.st != DS_RD) begin
            next_s.sh = {s.sh[6:0], bus.sda}; // RULE12
          end
          next_s.cnt = s.cnt + 4'h1;
        end else if (s.cnt == `RGIC_ACK_SLOT && s.st == DS_RD) begin
          next_s.mnack = bus.sda; // RULE14
        end
      end else if (scl_fall) begin
        // every drive change happens on a falling clock
        if (s.cnt == `RGIC_BITS) begin
          next_s.cnt = `RGIC_ACK_SLOT; // RULE12
          case (s.st)
            DS_ADDR: begin
              if (s.sh[7:1] == `RGIC_SLAVE_ADDR) begin
                next_s.sda_oe = 1'b1; // RULE13
                next_s.rw     = s.sh[0]; // RULE15
              end else begin
                next_s.st     = DS_SKIP; // RULE8
                next_s.sda_oe = 1'b0; // RULE16
              end
            end
            DS_RD: begin
              next_s.sda_oe = 1'b0; // master owns this slot
            end
            default: begin
              next_s.sda_oe = 1'b1; // RULE14
            end
          endcase
        end else if (s.cnt == `RGIC_ACK_SLOT) begin
          // end of the acknowledge slot
          next_s.cnt    = 4'h0;
          next_s.sda_oe = 1'b0;
          case (s.st)
            DS_ADDR: begin
              if (s.rw == `RGIC_DIR_READ) begin
                next_s.st     = DS_RD;
                next_s.sh     = rd_cur; // RULE19
                next_s.sda_oe = ~rd_cur[7]; // RULE11
              end else begin
                next_s.st = DS_REG; // RULE17
              end
            end
            DS_REG: begin
              next_s.ptr = s.sh; // RULE17
              next_s.st  = DS_WR;
            end
            DS_WR: begin
              // store, then move to the next register for burst writes
              if (s.ptr == `RGIC_REG_A) begin
                next_s.reg_a = s.sh; // RULE19
              end else if (s.ptr == `RGIC_REG_B) begin
                next_s.reg_b = s.sh; // RULE19
              end
              next_s.ptr = s.ptr + 8'h01;
            end
            DS_RD: begin
              if (s.mnack) begin
                next_s.st = DS_SKIP; // master is done, wait for stop
              end else begin
                next_s.ptr    = s.ptr + 8'h01;
                next_s.sh     = rd_nxt; // RULE19
                next_s.sda_oe = ~rd_nxt[7];
              end
            end
            default: begin
              next_s.st = DS_IDLE;
            end
          endcase
        end else if (s.st == DS_RD) begin
          // shift out the next bit while clock is low
          next_s.sh     = {s.sh[6:0], 1'b0};
          next_s.sda_oe = ~s.sh[6]; // RULE11
        end
      end
    end

    // enable decision: pin first, then the selected software bit
    next_s.en_q          = en_pin;
    next_s.powerup_start = en_pin & ~s.en_q; // RULE2
    next_s.converter_on  = en_pin & sw_en; // RULE1
    next_s.vout_code     = voltage_select_pin ? s.reg_b[`RGIC_CODE_MSB:0] : s.reg_a[`RGIC_CODE_MSB:0];
    next_s.forced_pwm    = voltage_select_pin ? s.reg_b[`RGIC_MODE_BIT] : s.reg_a[`RGIC_MODE_BIT];

    // blanking: the guard must stay high for the whole interval; any gap restarts it
    if (!input_overvoltage_guard) begin
      next_s.ovp_cnt  = '0;
      next_s.ovp_trip = 1'b0;
    end else begin
      if (s.ovp_cnt != `RGIC_OVP_CW'(`RGIC_OVP_CYC)) begin
        next_s.ovp_cnt = s.ovp_cnt + `RGIC_OVP_CW'(1);
      end
      next_s.ovp_trip = (s.ovp_cnt == `RGIC_OVP_CW'(`RGIC_OVP_CYC)); // RULE5
    end
    next_s.switching_on = en_pin & sw_en & ~s.ovp_trip; // RULE5
  end

  // state register; software enables come up set so the pin alone turns on
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s               <= '0;
      s.st            <= DS_IDLE;
      s.scl_q         <= 1'b1;
      s.sda_q         <= 1'b1;
      s.reg_a         <= `RGIC_REG_RESET; // RULE4
      s.reg_b         <= `RGIC_REG_RESET; // RULE18
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign bus.dev_sda_o  = s.sda_o;
  assign bus.dev_sda_oe = s.sda_oe;
  assign powerup_start  = s.powerup_start;
  assign converter_on   = s.converter_on;
  assign switching_on   = s.switching_on;
  assign ovp_trip       = s.ovp_trip;
  assign vout_code      = s.vout_code;
  assign forced_pwm     = s.forced_pwm;

endmodule

// [rgic_host.sv]
// host end: bus master issuing single-register writes and reads
`timescale 1ns/1ps
`include "rgic_consts.svh"
module rgic_host
  import rgic_pkg::*;
#(
  parameter logic [`RGIC_QCW-1:0] QUARTER = `RGIC_QCW'(`RGIC_QUARTER_CYC)
)
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // serial link
  rgic_bus_if.host        bus,
  // command port
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  // answer
  output logic            done,
  output logic            nack_err,
  output logic [7:0]      rdata
);

  rgic_host_t s;
  rgic_host_t next_s;
  logic       tick;

  // byte to send at each sequence position
  function automatic logic [7:0] seg_byte(input logic [2:0] seg, input logic [7:0] radr, input logic [7:0] wd);
    logic [7:0] v;
    v = 8'h00;
    case (seg)
      `RGIC_SEG_ADDR_W: v = {`RGIC_SLAVE_ADDR, `RGIC_DIR_WRITE}; // RULE15
      `RGIC_SEG_REG:    v = radr; // RULE17
      `RGIC_SEG_WDATA:  v = wd;
      `RGIC_SEG_ADDR_R: v = {`RGIC_SLAVE_ADDR, `RGIC_DIR_READ}; // RULE15
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // quarter-period tick keeps the clock at or below the ceiling
  assign tick = (s.qcnt == QUARTER - `RGIC_QCW'(1)); // RULE6

  always_comb begin
    next_s       = s;
    next_s.done  = 1'b0;
    next_s.scl_o = 1'b0;
    next_s.sda_o = 1'b0;
    next_s.qcnt  = (s.st == HS_IDLE || tick) ? '0 : s.qcnt + `RGIC_QCW'(1);
    case (s.st)
      HS_IDLE: begin
        if (cmd_valid) begin
          next_s.rd       = cmd_read;
          next_s.reg_adr  = cmd_reg;
          next_s.wdata    = cmd_wdata;
          next_s.seg      = `RGIC_SEG_ADDR_W;
          next_s.nack_err = 1'b0;
          next_s.ready    = 1'b0;
          next_s.ph       = 2'h0;
          next_s.st       = HS_START;
        end
      end
      HS_START: begin
        if (tick) begin
          next_s.ph = s.ph + 2'h1;
          case (s.ph)
            2'h0: next_s.sda_oe = 1'b0; // both lines high first
            2'h1: next_s.sda_oe = 1'b1; // RULE10
            2'h2: next_s.scl_oe = 1'b1;
            default: begin
              next_s.st   = HS_BIT;
              next_s.bitn = 4'h0;
              next_s.sh   = seg_byte(s.seg, s.reg_adr, s.wdata);
            end
          endcase
        end
      end
      HS_BIT: begin
        if (tick) begin
          next_s.ph = s.ph + 2'h1;
          case (s.ph)
            2'h0: begin
              // data set up while clock low; released for reading and ack slot
              next_s.sda_oe = (s.bitn < `RGIC_BITS && s.seg != `RGIC_SEG_RDATA) ? ~s.sh[7] : 1'b0; // RULE11
            end
            2'h1: next_s.scl_oe = 1'b0;
            2'h2: begin
              if (s.bitn < `RGIC_BITS) begin
                next_s.rx = {s.rx[6:0], bus.sda}; // RULE12
              end else if (s.seg != `RGIC_SEG_RDATA && bus.sda) begin
                next_s.nack_err = 1'b1; // RULE16
              end
            end
            default: begin
              next_s.scl_oe = 1'b1;
              next_s.sh     = {s.sh[6:0], 1'b0};
              next_s.bitn   = s.bitn + 4'h1;
              if (s.bitn == `RGIC_BITS) begin
                next_s.bitn = 4'h0;
                // a single read byte is not acknowledged, which ends the read
                if (s.nack_err || s.seg == `RGIC_SEG_WDATA || (s.seg == `RGIC_SEG_REG && s.rd)) begin
                  next_s.st = HS_STOP;
                end else if (s.seg == `RGIC_SEG_RDATA) begin
                  next_s.rdata = s.rx;
                  next_s.st    = HS_STOP;
                end else begin
                  next_s.seg = s.seg + 3'h1;
                  next_s.sh  = seg_byte(s.seg + 3'h1, s.reg_adr, s.wdata);
                end
              end
            end
          endcase
        end
      end
      HS_STOP: begin
        if (tick) begin
          next_s.ph = s.ph + 2'h1;
          case (s.ph)
            2'h0: next_s.sda_oe = 1'b1;
            2'h1: next_s.scl_oe = 1'b0;
            2'h2: next_s.sda_oe = 1'b0; // rising data while clock high
            default: begin
              // reads restart only after a stop, never a repeated start
              if (s.seg == `RGIC_SEG_REG && s.rd && !s.nack_err) begin
                next_s.seg = `RGIC_SEG_ADDR_R; // RULE10
                next_s.st  = HS_START;
              end else begin
                next_s.st = HS_DONE;
              end
            end
          endcase
        end
      end
      HS_DONE: begin
        next_s.done  = 1'b1;
        next_s.ready = 1'b1;
        next_s.st    = HS_IDLE;
      end
      default: begin
        next_s.st = HS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s       <= '0;
      s.st    <= HS_IDLE;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign bus.host_scl_o  = s.scl_o;
  assign bus.host_scl_oe = s.scl_oe;
  assign bus.host_sda_o  = s.sda_o;
  assign bus.host_sda_oe = s.sda_oe;
  assign cmd_ready       = s.ready;
  assign done            = s.done;
  assign nack_err        = s.nack_err;
  assign rdata           = s.rdata;

endmodule

// [rgic_assertions.sv]
// bus checker for the host to regulator serial link
`timescale 1ns/1ps
`include "rgic_consts.svh"
module rgic_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link signals
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int MIN_PER = 37; // core cycles per scl period at 3.4MHz, rounded up
  logic       scl_p, sda_p, busy, rw, match, start_ev, stop_ev, rise;
  logic [3:0] bitc;
  logic [1:0] byten;
  logic [7:0] sh, per;

  // line events judged against the previous sample, as the device does
  assign start_ev = scl & scl_p & sda_p & ~sda;
  assign stop_ev  = scl & scl_p & ~sda_p & sda;
  assign rise     = scl & ~scl_p;

  // frame tracker; per saturates so long idle gaps never wrap into a false short period
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {scl_p, sda_p, per} <= 10'h3ff;
      {busy, rw, match, bitc, byten, sh} <= '0;
    end else begin
      scl_p <= scl;
      sda_p <= sda;
      per   <= rise ? 8'h01 : per + {7'h0, per != 8'hff};
      if (start_ev) begin
        busy <= 1'b1;
        {bitc, byten} <= 6'h00;
      end else if (stop_ev) begin
        busy <= 1'b0;
      end else if (rise && busy) begin
        if (bitc == 4'h8) begin
          bitc  <= 4'h0;
          byten <= byten + 2'h1;
          if (byten == 2'h0) begin
            match <= sh[7:1] == `RGIC_SLAVE_ADDR;
            rw    <= sh[0];
          end
        end else begin
          bitc <= bitc + 4'h1;
          sh   <= {sh[6:0], sda};
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ninth clock of a byte, and a stop on the wire
  sequence s_ninth; rise && busy && bitc == 4'h8; endsequence
  sequence s_stop; stop_ev; endsequence

  property p_dev_hold; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device moved sda while scl high");
  property p_host_hold; busy && scl && $past(scl) && !stop_ev |-> $stable(host_sda_oe); endproperty
  a_host_hold: assert property (p_host_hold) else $error("host moved sda while scl high");
  property p_open_drain; host_scl_o == 1'b0 && host_sda_o == 1'b0 && dev_sda_o == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("a line driven high");
  property p_idle; !busy |-> !dev_sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("device drives sda outside a frame");
  property p_ack_own; s_ninth ##0 (byten == 2'h0 && sh[7:1] == `RGIC_SLAVE_ADDR) |-> dev_sda_oe; endproperty
  a_ack_own: assert property (p_ack_own) else $error("own address not acknowledged");
  property p_ack_bytes; s_ninth ##0 (byten != 2'h0 && match && !rw) |-> dev_sda_oe; endproperty
  a_ack_bytes: assert property (p_ack_bytes) else $error("written byte not acknowledged");
  property p_rate; rise |-> per >= MIN_PER; endproperty
  a_rate: assert property (p_rate) else $error("scl period too short");
  property p_stop_release; s_stop |=> !dev_sda_oe [*4]; endproperty
  a_stop_release: assert property (p_stop_release) else $error("sda held after stop");
  property p_whole; s_stop |-> bitc == 4'h1; endproperty
  a_whole: assert property (p_whole) else $error("frame ended inside a byte");
  property p_start_host; start_ev |-> host_sda_oe && !dev_sda_oe; endproperty
  a_start_host: assert property (p_start_host) else $error("start not made by host");
endmodule

// [tb_top.sv]
// testbench: host and regulator ends joined, checked against a register model
`timescale 1ns/1ps
`include "rgic_consts.svh"
module tb_top;
  logic       core_clk, nrst, en_pin, voltage_select_pin, input_overvoltage_guard;
  logic       cmd_valid, cmd_read, cmd_ready, done, nack_err;
  logic       powerup_start, converter_on, switching_on, ovp_trip, forced_pwm;
  logic [7:0] cmd_reg, cmd_wdata, rdata, r, d;
  logic [5:0] vout_code, vout_b;
  logic [7:0] model [2];
  int         n_errors, compares, pu_cnt, trip_cnt, seed, i;

  rgic_bus_if bus_if ();
  rgic_bus_if bus_b ();
  rgic_host rgic_host_inst (.core_clk, .nrst, .bus(bus_if), .cmd_valid, .cmd_read, .cmd_reg, .cmd_wdata,
                            .cmd_ready, .done, .nack_err, .rdata);
  rgic_dev rgic_dev_inst (.core_clk, .nrst, .bus(bus_if), .en_pin, .voltage_select_pin, .input_overvoltage_guard,
                          .powerup_start, .converter_on, .switching_on, .ovp_trip, .vout_code, .forced_pwm);
  // second regulator on its own link, bit-banged by the bench to misbehave
  rgic_dev rgic_dev_fault_inst (.core_clk, .nrst, .bus(bus_b), .en_pin, .voltage_select_pin,
                                .input_overvoltage_guard, .powerup_start(), .converter_on(), .switching_on(),
                                .ovp_trip(), .vout_code(vout_b), .forced_pwm());
  rgic_assertions rgic_assertions_inst (.core_clk, .nrst, .host_scl_o(bus_if.host_scl_o),
                                        .host_scl_oe(bus_if.host_scl_oe), .host_sda_o(bus_if.host_sda_o),
                                        .host_sda_oe(bus_if.host_sda_oe), .dev_sda_o(bus_if.dev_sda_o),
                                        .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // pulse counters see the value from before the edge's updates
  always @(posedge core_clk) begin
    if (powerup_start === 1'b1) pu_cnt++;
    if (ovp_trip === 1'b1) trip_cnt++;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one command; ready is already high after the previous done, so it is taken at the next edge
  task automatic cmd(input logic rd, input logic [7:0] ra, input logic [7:0] wd);
    int k;
    {cmd_read, cmd_reg, cmd_wdata, cmd_valid} = {rd, ra, wd, 1'b1};
    step(1);
    cmd_valid = 1'b0;
    chk("cmd_ready taken", 8'h00, {7'h0, cmd_ready});
    for (k = 0; k < 3000 && done !== 1'b1; k++) step(1);
    if (k >= 3000) begin
      n_errors++;
      $display("[FAIL] done expected 1 seen 0");
      test_done();
    end
    if (!rd && ra < 8'h02) model[ra[0]] = wd;
    chk("cmd_ready done", 8'h01, {7'h0, cmd_ready});
    chk("nack_err", 8'h00, {7'h0, nack_err});
    if (rd) chk("rdata", ra < 8'h02 ? model[ra[0]] : 8'h00, rdata);
  endtask

  // every select and enable pairing against the model
  task automatic check_outs;
    int p;
    logic [7:0] v;
    for (int s = 0; s < 2; s++) begin
      for (int e = 0; e < 2; e++) begin
        p = pu_cnt;
        voltage_select_pin = s[0];
        en_pin = e[0];
        step(4);
        v = model[s];
        chk("converter_on", {7'h0, e[0] & v[7]}, {7'h0, converter_on});
        chk("switching_on", {7'h0, e[0] & v[7]}, {7'h0, switching_on});
        chk("vout_code", {2'h0, v[5:0]}, {2'h0, vout_code});
        chk("forced_pwm", {7'h0, v[6]}, {7'h0, forced_pwm});
        chk("powerup_start", 8'(e), 8'(pu_cnt - p));
      end
    end
  endtask

  // one level on the second link; 13 cycles a level keeps scl under 3.4MHz
  task automatic bb(input logic scl_lo, input logic sda_lo);
    {bus_b.host_scl_oe, bus_b.host_sda_oe} = {scl_lo, sda_lo};
    step(13);
  endtask

  // data changes only with scl low; the ninth bit is sent released so k shows the acknowledge
  task automatic send(input logic [8:0] w, input int nb, output logic k);
    for (int j = 8; j > 8 - nb; j--) begin
      bb(1'b1, bus_b.host_sda_oe);
      bb(1'b1, ~w[j]);
      bb(1'b0, ~w[j]);
      k = ~bus_b.sda;
    end
  endtask

  task automatic frame(input logic [7:0] a, input logic [7:0] ra, input logic [7:0] wd, input int nb,
                       input logic ack);
    logic k;
    bb(1'b0, 1'b1);
    send({a, 1'b1}, 9, k);
    chk("fault addr ack", {7'h0, ack}, {7'h0, k});
    send({ra, 1'b1}, 9, k);
    send({wd, 1'b1}, nb, k);
    bb(1'b1, bus_b.host_sda_oe);
    bb(1'b1, 1'b1);
    bb(1'b0, 1'b1);
    bb(1'b0, 1'b0);
  endtask

  initial begin
    seed = $urandom(32'h6248cda6);
    {nrst, en_pin, voltage_select_pin, input_overvoltage_guard, cmd_valid, cmd_read} = 6'h00;
    {cmd_reg, cmd_wdata} = 16'h0000;
    {bus_b.host_scl_o, bus_b.host_sda_o, bus_b.host_scl_oe, bus_b.host_sda_oe} = 4'h0;
    {n_errors, compares, pu_cnt, trip_cnt} = '0;
    model[0] = `RGIC_REG_RESET;
    model[1] = `RGIC_REG_RESET;
    step(16);
    nrst = 1'b1;
    check_outs();
    cmd(1'b1, `RGIC_REG_A, 8'h00);
    cmd(1'b1, `RGIC_REG_B, 8'h00);
    // random writes then reads back to back, unmapped registers among them
    for (i = 0; i < 8; i++) begin
      r = 8'($urandom % 4);
      d = 8'($urandom);
      cmd(1'b0, r, d);
      cmd(1'b1, r, 8'h00);
      if (i[0]) check_outs();
    end
    // known enable and forced mode on the second register, so the guard test can see switching drop
    cmd(1'b0, `RGIC_REG_B, 8'hc5);
    check_outs();
    // a spike shorter than the blank is ignored, a longer one stops switching
    input_overvoltage_guard = 1'b1;
    step(`RGIC_OVP_CYC - 2);
    input_overvoltage_guard = 1'b0;
    step(4);
    chk("ovp_trip short", 8'h00, 8'(trip_cnt));
    input_overvoltage_guard = 1'b1;
    step(`RGIC_OVP_CYC + 4);
    chk("ovp_trip", 8'h01, {7'h0, ovp_trip});
    chk("switching_on trip", 8'h00, {7'h0, switching_on});
    input_overvoltage_guard = 1'b0;
    step(4);
    chk("switching_on after", {7'h0, model[1][7]}, {7'h0, switching_on});
    // second link: foreign address ignored, own address stored, aborted byte dropped
    voltage_select_pin = 1'b0;
    frame(8'h82, 8'h00, 8'h05, 9, 1'b0);
    chk("fault vout foreign", `RGIC_REG_RESET & 8'h3f, {2'h0, vout_b});
    frame(8'h80, 8'h00, 8'h05, 9, 1'b1);
    chk("fault vout own", 8'h05, {2'h0, vout_b});
    voltage_select_pin = 1'b1;
    frame(8'h80, 8'h01, 8'h05, 4, 1'b1);
    chk("fault vout abort", `RGIC_REG_RESET & 8'h3f, {2'h0, vout_b});
    test_done();
  end
endmodule
